// *** rtl/gtsr_pkg.sv ***
// What this block does
// - Status bits 3-1 report memory size, reset 0Ah
// - Test mode field works only with bit 7, except as debug select under bit 6
// - Counter muxes CRT counter slices onto system data
// - Scan test substitutes system data for font/attribute in text mode, for shifter data otherwise
// - Bit 4 flushes write cache after writes
// - Each bit 5 change toggles vertical sync once
// - Debug bit routes selected internal signals out
// - Debug pins carry address, state, frame, command
// - Coprocessor test bit forces skip and ready
// - Clock select bits drive pins, mirror sources
// - Strap register one latched from low byte
// - Strap bits 4-2 encode system bus type
// - Strap bits 7-5 encode memory organisation
// - Strap register two latched; pixel/converter options
// - ROM decode enable and ROM size fields
// - Strap bit 5 picks x16 strobe style
// - Fast-write and bus speed strap flags
// - Strap three latched; selects select timing 01/10
// - Strap three bit 1 forces multi-function flag
// - Strap three bit 2 selects ROM addressing
package gtsr_pkg;
  // ==========================================================
  // Register indices behind the data port
  localparam logic [7:0] IDX_MEM_STATUS  = 8'h02;
  localparam logic [7:0] IDX_TEST_CTL    = 8'h03;
  localparam logic [7:0] IDX_COPRO_TEST  = 8'h04;
  localparam logic [7:0] IDX_VCLK_SEL    = 8'h06;
  localparam logic [7:0] IDX_STRAP_ONE   = 8'h07;
  localparam logic [7:0] IDX_STRAP_TWO   = 8'h08;
  localparam logic [7:0] IDX_STRAP_THREE = 8'h09;
  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] MEM_STATUS_RST  = 8'h0A;
  localparam logic [7:0] MEM_STATUS_MASK = 8'h0E;
  localparam logic [7:0] TEST_CTL_RST    = 8'h00;
  localparam logic [7:0] COPRO_TEST_RST  = 8'h00;
  localparam logic [7:0] VCLK_SEL_RST    = 8'h00;
  localparam logic [7:0] STRAP_RST       = 8'h00;
  // ==========================================================
  // Test control field positions
  localparam int TC_MODE_LSB  = 0;
  localparam int TC_FLUSH     = 4;
  localparam int TC_VSYNC     = 5;
  localparam int TC_DEBUG     = 6;
  localparam int TC_GLOBAL    = 7;
  localparam logic [2:0] MODE_CRT_CNT  = 3'h0;
  localparam logic [2:0] MODE_SCAN_ATR = 3'h5;
  localparam logic [2:0] DBG_RESERVED  = 3'h7;
  // ==========================================================
  // Strap bus layout and bus type codes
  localparam int STRAP_ONE_LSB   = 0;
  localparam int STRAP_TWO_LSB   = 8;
  localparam int STRAP_THREE_LSB = 16;
  localparam logic [2:0] BUS_PCI = 3'h4;
  localparam logic [2:0] BUS_ISA = 3'h7;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic [1:0] DEVSEL_SLOW   = 2'h2;
endpackage

// *** rtl/gtsr_top.sv ***
`timescale 1ns/1ps
module gtsr_top #(
  parameter int DBG_SRCS = 7
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  port_sel_i,
  input  wire logic                  port_wr_i,
  input  wire logic                  port_rd_i,
  input  wire logic [7:0]            port_wdata_i,
  output logic      [7:0]            port_rdata_o,
  input  wire logic [23:0]           memory_data_strap_bus_i,
  input  wire logic [1:0]            misc_output_reg_clk_i,
  input  wire logic                  misc_output_reg_wr_i,
  input  wire logic                  ext_reg_d_clk_i,
  input  wire logic                  ext_reg_d_wr_i,
  output logic      [3:0]            clock_select_pins_o,
  input  wire logic [10:0]           crt_vert_i,
  input  wire logic [4:0]            crt_row_i,
  input  wire logic [22:0]           crt_addr_i,
  input  wire logic [15:0]           crt_horz_i,
  input  wire logic [15:0]           system_data_pins_i,
  output logic      [15:0]           system_data_pins_o,
  output logic                       system_data_oe_o,
  input  wire logic                  text_mode_i,
  input  wire logic [7:0]            font_data_i,
  input  wire logic [7:0]            attr_data_i,
  input  wire logic [7:0]            graphics_pixel_data_i,
  output logic      [7:0]            font_data_o,
  output logic      [7:0]            attr_data_o,
  output logic      [7:0]            shifter_data_o,
  input  wire logic                  mem_write_done_i,
  output logic                       cache_flush_o,
  input  wire logic                  vsync_i,
  output logic                       vsync_o,
  input  wire logic [23:0]           pixel_i,
  input  wire logic [8*DBG_SRCS-1:0] debug_src_i,
  output logic      [23:0]           pixel_o,
  input  wire logic                  copro_ready_i,
  output logic                       copro_skip_o,
  output logic                       copro_ready_o,
  output logic                       rom_16bit_o,
  output logic                       addon_enable_o,
  output logic      [2:0]            bus_type_o,
  output logic      [2:0]            dram_type_o,
  output logic                       pixel_bus_16_o,
  output logic                       vl_aux_selects_o,
  output logic                       converter_port_24_o,
  output logic                       rom_decode_en_o,
  output logic      [1:0]            rom_size_o,
  output logic                       split_column_strobe_o,
  output logic                       fast_write_o,
  output logic                       bus_slow_o,
  output logic      [1:0]            devsel_timing_o,
  output logic                       multi_function_o,
  output logic                       alt_rom_addr_o
);
  import gtsr_pkg::*;

  // ==========================================================
  // Reset release
  logic       rst_meta_q;
  logic       rst_n_q;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================
  // Functions
  function automatic logic [15:0] crt_slice(input logic [2:0] sel, input logic [10:0] v,
                                            input logic [4:0] r, input logic [22:0] a,
                                            input logic [15:0] h);
    case (sel)
      3'h1:    crt_slice = {8'h00, v[10:8], r};
      3'h3:    crt_slice = {8'h00, a[7:0]};
      3'h4:    crt_slice = a[15:0] >> 3;
      3'h5:    crt_slice = {9'h000, a[22:16]};
      3'h6:    crt_slice = {8'h00, h[7:0]};
      3'h7:    crt_slice = {8'h00, h[15:8]};
      default: crt_slice = {5'h00, v};
    endcase
  endfunction

  function automatic logic is_vl(input logic [2:0] bt);
    is_vl = (bt != BUS_PCI) && (bt != BUS_ISA);
  endfunction

  // ==========================================================
  // Index/data port
  logic [7:0] index_q;
  logic [7:0] mem_status_q;
  logic [7:0] test_ctl_q;
  logic [7:0] copro_test_q;
  logic [7:0] vclk_q;
  logic [7:0] strap_one_q;
  logic [7:0] strap_two_q;
  logic [7:0] strap_three_q;
  logic       strap_done_q;
  logic       data_wr;

  assign data_wr = port_wr_i && port_sel_i;

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      index_q <= 8'h00;
    end else if (port_wr_i && !port_sel_i) begin
      index_q <= port_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_status_q <= MEM_STATUS_RST;
      test_ctl_q   <= TEST_CTL_RST;
      copro_test_q <= COPRO_TEST_RST;
    end else if (data_wr) begin
      case (index_q)
        IDX_MEM_STATUS: mem_status_q <= port_wdata_i & MEM_STATUS_MASK;
        IDX_TEST_CTL:   test_ctl_q   <= port_wdata_i;
        IDX_COPRO_TEST: copro_test_q <= port_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Mirror updates win over the port so the pins track the last source written
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      vclk_q <= VCLK_SEL_RST;
    end else begin
      if (data_wr && index_q == IDX_VCLK_SEL) begin
        vclk_q <= port_wdata_i;
      end
      if (misc_output_reg_wr_i) begin
        vclk_q[1:0] <= misc_output_reg_clk_i;
      end
      if (ext_reg_d_wr_i) begin
        vclk_q[2] <= ext_reg_d_clk_i;
      end
    end
  end
  assign clock_select_pins_o = vclk_q[3:0];

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      port_rdata_o <= 8'h00;
    end else if (port_rd_i) begin
      if (!port_sel_i) begin
        port_rdata_o <= index_q;
      end else begin
        case (index_q)
          IDX_MEM_STATUS:  port_rdata_o <= mem_status_q;
          IDX_TEST_CTL:    port_rdata_o <= test_ctl_q;
          IDX_COPRO_TEST:  port_rdata_o <= copro_test_q;
          IDX_VCLK_SEL:    port_rdata_o <= vclk_q;
          IDX_STRAP_ONE:   port_rdata_o <= strap_one_q;
          IDX_STRAP_TWO:   port_rdata_o <= strap_two_q;
          IDX_STRAP_THREE: port_rdata_o <= strap_three_q;
          default:         port_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // Strap capture, one clock after reset release
  // Port writes never reach these flops, so they hold until the next reset
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      strap_done_q  <= 1'b0;
      strap_one_q   <= STRAP_RST;
      strap_two_q   <= STRAP_RST;
      strap_three_q <= STRAP_RST;
    end else if (!strap_done_q) begin
      strap_done_q  <= 1'b1;
      strap_one_q   <= memory_data_strap_bus_i[STRAP_ONE_LSB +: 8];
      strap_two_q   <= memory_data_strap_bus_i[STRAP_TWO_LSB +: 8];
      strap_three_q <= memory_data_strap_bus_i[STRAP_THREE_LSB +: 8];
    end
  end

  assign rom_16bit_o           = strap_one_q[0];
  assign addon_enable_o        = strap_one_q[1];
  assign bus_type_o            = strap_one_q[4:2];
  assign dram_type_o           = strap_one_q[7:5];
  assign pixel_bus_16_o        = strap_two_q[0];
  assign vl_aux_selects_o      = strap_two_q[1] && is_vl(strap_one_q[4:2]);
  assign converter_port_24_o   = strap_two_q[1] && !is_vl(strap_one_q[4:2]);
  assign rom_decode_en_o       = strap_two_q[2];
  assign rom_size_o            = strap_two_q[4:3];
  assign split_column_strobe_o = strap_two_q[5];
  assign fast_write_o          = strap_two_q[6];
  assign bus_slow_o            = strap_two_q[7];
  assign devsel_timing_o       = strap_three_q[0] ? DEVSEL_SLOW : DEVSEL_MEDIUM;
  assign multi_function_o      = strap_three_q[1];
  assign alt_rom_addr_o        = strap_three_q[2];

  // ==========================================================
  // Test modes
  logic       crt_test;
  logic       scan_test;
  logic [2:0] crt_cnt_q;
  assign crt_test  = test_ctl_q[TC_GLOBAL] && test_ctl_q[TC_MODE_LSB +: 3] == MODE_CRT_CNT;
  assign scan_test = test_ctl_q[TC_GLOBAL] && test_ctl_q[TC_MODE_LSB +: 3] == MODE_SCAN_ATR;

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      crt_cnt_q <= 3'h0;
    end else if (crt_test) begin
      crt_cnt_q <= crt_cnt_q + 3'h1;
    end else begin
      crt_cnt_q <= 3'h0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      system_data_pins_o <= 16'h0000;
      system_data_oe_o   <= 1'b0;
    end else begin
      system_data_oe_o   <= crt_test;
      system_data_pins_o <= crt_test ? crt_slice(crt_cnt_q, crt_vert_i, crt_row_i, crt_addr_i, crt_horz_i)
                                     : 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      font_data_o    <= 8'h00;
      attr_data_o    <= 8'h00;
      shifter_data_o <= 8'h00;
    end else begin
      font_data_o    <= (scan_test && text_mode_i) ? system_data_pins_i[15:8] : font_data_i;
      attr_data_o    <= (scan_test && text_mode_i) ? system_data_pins_i[7:0] : attr_data_i;
      shifter_data_o <= (scan_test && !text_mode_i) ? system_data_pins_i[15:8] : graphics_pixel_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cache_flush_o <= 1'b0;
    end else begin
      cache_flush_o <= mem_write_done_i && test_ctl_q[TC_FLUSH];
    end
  end

  // Bit 5 history gives one toggle per change, however it was written
  logic vs_prev_q;
  logic vsync_inv_q;
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      vs_prev_q   <= 1'b0;
      vsync_inv_q <= 1'b0;
    end else begin
      vs_prev_q <= test_ctl_q[TC_VSYNC];
      if (vs_prev_q != test_ctl_q[TC_VSYNC]) begin
        vsync_inv_q <= ~vsync_inv_q;
      end
    end
  end
  assign vsync_o = vsync_i ^ vsync_inv_q;

  // ==========================================================
  // Debug pin routing; each source byte is {addr[2:0], state[2:0], frame, cmd}
  logic [2:0] dbg_sel;
  assign dbg_sel = test_ctl_q[TC_MODE_LSB +: 3];
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pixel_o <= 24'h000000;
    end else if (test_ctl_q[TC_DEBUG] && dbg_sel != DBG_RESERVED && int'(dbg_sel) < DBG_SRCS) begin
      pixel_o <= {debug_src_i[8*dbg_sel +: 8], pixel_i[15:0]};
    end else if (test_ctl_q[TC_DEBUG]) begin
      pixel_o <= {8'h00, pixel_i[15:0]};
    end else begin
      pixel_o <= pixel_i;
    end
  end

  // ==========================================================
  // Coprocessor speed test
  assign copro_skip_o  = copro_test_q[0];
  assign copro_ready_o = copro_test_q[0] || copro_ready_i;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_vclk_wr;
    data_wr && index_q == IDX_VCLK_SEL && !misc_output_reg_wr_i && !ext_reg_d_wr_i;
  endsequence
  sequence s_strap_held;
    strap_done_q ##1 strap_done_q;
  endsequence
  sequence s_scan_text;
    scan_test && text_mode_i;
  endsequence
  sequence s_scan_gfx;
    scan_test && !text_mode_i;
  endsequence

  a_strap_hold_ro: assert property (s_strap_held |-> $stable(strap_one_q) && $stable(strap_two_q)
                                    && $stable(strap_three_q)) else $error("strap register changed");
  a_vclk_pins_track: assert property (s_vclk_wr |=> clock_select_pins_o == $past(port_wdata_i[3:0]))
    else $error("clock select pins wrong");
  a_misc_mirror: assert property (misc_output_reg_wr_i |=>
                                  clock_select_pins_o[1:0] == $past(misc_output_reg_clk_i))
    else $error("misc mirror lost");
  a_flush_after_wr: assert property (mem_write_done_i && test_ctl_q[TC_FLUSH] |=> cache_flush_o)
    else $error("missing cache flush");
  a_no_flush_idle: assert property (!test_ctl_q[TC_FLUSH] |=> !cache_flush_o)
    else $error("unexpected cache flush");
  a_vsync_toggle: assert property ($changed(test_ctl_q[TC_VSYNC]) |=>
                                   $changed(vsync_inv_q) ##1 $stable(vsync_inv_q))
    else $error("vsync toggle wrong");
  a_crt_gate_off: assert property (!test_ctl_q[TC_GLOBAL] |=> !system_data_oe_o)
    else $error("test output without global enable");
  a_crt_counter_step: assert property (crt_test ##1 crt_test |-> crt_cnt_q == $past(crt_cnt_q) + 3'h1)
    else $error("crt counter stalled");
  a_copro_ready: assert property (copro_test_q[0] |-> copro_ready_o && copro_skip_o)
    else $error("coprocessor not forced ready");
  a_devsel_code: assert property (devsel_timing_o != 2'h0 && devsel_timing_o != 2'h3)
    else $error("illegal select timing");
  a_debug_route: assert property (test_ctl_q[TC_DEBUG] && dbg_sel == 3'h2 |=>
                                  pixel_o[23:16] == $past(debug_src_i[23:16]))
    else $error("debug pins wrong");
  a_mem_size_rst: assert property ($rose(rst_n_q) |-> mem_status_q == MEM_STATUS_RST)
    else $error("status reset value wrong");
  a_scan_font_sub: assert property (s_scan_text |=> {font_data_o, attr_data_o} == $past(system_data_pins_i))
    else $error("scan text data not substituted");
  a_scan_shift_sub: assert property (s_scan_gfx |=> shifter_data_o == $past(system_data_pins_i[15:8]))
    else $error("scan shifter data not substituted");
  // Sampled reset keeps the release edge out, where the pixel flop is still held in reset
  a_debug_off_pass: assert property (rst_n_q && !test_ctl_q[TC_DEBUG] |=> pixel_o == $past(pixel_i))
    else $error("pixel pass-through lost");
  a_crt_count_restart: assert property (!crt_test |=> crt_cnt_q == 3'h0)
    else $error("crt counter not restarted");
  a_crt_oe_on: assert property (crt_test |=> system_data_oe_o)
    else $error("crt test output not enabled");
  a_copro_normal: assert property (!copro_test_q[0] |-> copro_ready_o == copro_ready_i && !copro_skip_o)
    else $error("coprocessor not in normal mode");
endmodule

// *** test/gtsr_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Host software side of the index/data port
module gtsr_host_model (
  input  wire logic       clock_i,
  output logic            port_sel_o,
  output logic            port_wr_o,
  output logic            port_rd_o,
  output logic      [7:0] port_wdata_o,
  input  wire logic [7:0] port_rdata_i
);
  initial begin
    port_sel_o   = 1'b0;
    port_wr_o    = 1'b0;
    port_rd_o    = 1'b0;
    port_wdata_o = 8'h00;
  end
  // Index is always written before the data port is touched
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clock_i);
    port_sel_o   <= 1'b0;
    port_wr_o    <= 1'b1;
    port_wdata_o <= idx;
    @(posedge clock_i);
    port_sel_o   <= 1'b1;
    port_wdata_o <= dat;
    @(posedge clock_i);
    port_wr_o    <= 1'b0;
    // Idle data is scrambled so nothing leans on a stale value
    port_wdata_o <= ~dat;
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] dat);
    @(posedge clock_i);
    port_sel_o   <= 1'b0;
    port_wr_o    <= 1'b1;
    port_wdata_o <= idx;
    @(posedge clock_i);
    port_sel_o   <= 1'b1;
    port_wr_o    <= 1'b0;
    port_rd_o    <= 1'b1;
    port_wdata_o <= ~idx;
    @(posedge clock_i);
    port_rd_o    <= 1'b0;
    @(posedge clock_i);
    #1;
    dat = port_rdata_i;
  endtask
endmodule

// *** test/gtsr_top_tb.sv ***
`timescale 1ns/1ps
module gtsr_top_tb;
  import gtsr_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i, sel, wr, rd, mwr, ewr, ecl, txt, mdone, vs, cpr;
  logic        cfl, vso, cps, cpro, r16, aon, pb16, vlx, c24, romd, split, fw, slow, mf, alt, sdoe;
  logic [7:0]  wd, rdat, fnt, atr, gpx, r8, v, fo, ao, so;
  logic [1:0]  mcl, rsz, dsl;
  logic [2:0]  bty, dty;
  logic [3:0]  clock_select_pins;
  logic [23:0] strap, pix, pxo;
  logic [10:0] vert;
  logic [4:0]  row;
  logic [22:0] addr;
  logic [15:0] horz, sdi, sdo;
  logic [55:0] dbg;
  int          failures = 0;
  int          samples_checked = 0;
  int          seed = 32'hb77fa20a;

  always #2 clock_i = ~clock_i;

  gtsr_host_model host_u (.clock_i(clock_i), .port_sel_o(sel), .port_wr_o(wr), .port_rd_o(rd),
    .port_wdata_o(wd), .port_rdata_i(rdat));

  gtsr_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .port_sel_i(sel), .port_wr_i(wr), .port_rd_i(rd),
    .port_wdata_i(wd), .port_rdata_o(rdat), .memory_data_strap_bus_i(strap), .misc_output_reg_clk_i(mcl),
    .misc_output_reg_wr_i(mwr), .ext_reg_d_clk_i(ecl), .ext_reg_d_wr_i(ewr), .clock_select_pins_o(clock_select_pins),
    .crt_vert_i(vert), .crt_row_i(row), .crt_addr_i(addr), .crt_horz_i(horz), .system_data_pins_i(sdi),
    .system_data_pins_o(sdo), .system_data_oe_o(sdoe), .text_mode_i(txt), .font_data_i(fnt),
    .attr_data_i(atr), .graphics_pixel_data_i(gpx), .font_data_o(fo), .attr_data_o(ao), .shifter_data_o(so),
    .mem_write_done_i(mdone), .cache_flush_o(cfl), .vsync_i(vs), .vsync_o(vso), .pixel_i(pix),
    .debug_src_i(dbg), .pixel_o(pxo), .copro_ready_i(cpr), .copro_skip_o(cps), .copro_ready_o(cpro),
    .rom_16bit_o(r16), .addon_enable_o(aon), .bus_type_o(bty), .dram_type_o(dty), .pixel_bus_16_o(pb16),
    .vl_aux_selects_o(vlx), .converter_port_24_o(c24), .rom_decode_en_o(romd), .rom_size_o(rsz),
    .split_column_strobe_o(split), .fast_write_o(fw), .bus_slow_o(slow), .devsel_timing_o(dsl),
    .multi_function_o(mf), .alt_rom_addr_o(alt));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    host_u.rd_reg(idx, r8);
    chk("readback", r8, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // CRT slice expected for each value of the internal test counter
  function automatic logic [15:0] sl(input int k);
    case (k)
      1: return {8'h00, vert[10:8], row};
      3: return {8'h00, addr[7:0]};
      4: return {3'h0, addr[15:3]};
      5: return {9'h000, addr[22:16]};
      6: return {8'h00, horz[7:0]};
      7: return {8'h00, horz[15:8]};
      default: return {5'h00, vert};
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    end_of_test();
  end

  initial begin
    rst_n_i = 1'b0;
    {mwr, ewr, ecl, txt, mdone, vs, cpr, mcl} = '0;
    strap = 24'($random(seed));
    {fnt, atr, gpx, pix} = 48'({$random(seed), $random(seed)});
    {vert, row, addr, horz, sdi} = 71'({$random(seed), $random(seed), $random(seed)});
    dbg = 56'({$random(seed), $random(seed)});
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rdchk(IDX_MEM_STATUS, MEM_STATUS_RST);
    rdchk(IDX_TEST_CTL, 8'h00);
    rdchk(IDX_COPRO_TEST, 8'h00);
    rdchk(8'h55, 8'h00);
    // Straps must survive a write attempt
    for (int i = 0; i < 3; i++) begin
      host_u.wr_reg(IDX_STRAP_ONE + 8'(i), ~strap[8*i+:8]);
      rdchk(IDX_STRAP_ONE + 8'(i), strap[8*i+:8]);
    end
    chk("s1", {dty, bty, aon, r16}, strap[7:0]);
    chk("s2", {slow, fw, split, rsz, romd, pb16}, {strap[15:10], strap[8]});
    chk("c24", c24, strap[9] & (strap[4:2] == BUS_PCI || strap[4:2] == BUS_ISA));
    chk("vlx", vlx, strap[9] & strap[4:2] != BUS_PCI & strap[4:2] != BUS_ISA);
    chk("s3", {alt, mf, dsl}, {strap[18:17], strap[16] ? DEVSEL_SLOW : DEVSEL_MEDIUM});
    repeat (4) begin
      v = 8'($random(seed));
      host_u.wr_reg(IDX_MEM_STATUS, v);
      rdchk(IDX_MEM_STATUS, v & 8'h0E);
      host_u.wr_reg(IDX_VCLK_SEL, v);
      settle(2);
      chk("clock_select_pins", clock_select_pins, v[3:0]);
      rdchk(IDX_VCLK_SEL, v);
    end
    @(posedge clock_i);
    mcl <= ~v[1:0];
    mwr <= 1'b1;
    ecl <= ~v[2];
    ewr <= 1'b1;
    @(posedge clock_i);
    mwr <= 1'b0;
    ewr <= 1'b0;
    settle(2);
    chk("clock_select_pins_mirror", clock_select_pins, {v[3], ~v[2:0]});
    // The block's only reset stands in for the reset owed after a clock change; straps are read afresh
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    strap   <= ~strap;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    settle(4);
    chk("clock_select_pins_rst", clock_select_pins, 4'h0);
    rdchk(IDX_MEM_STATUS, MEM_STATUS_RST);
    rdchk(IDX_VCLK_SEL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rdchk(IDX_STRAP_ONE + 8'(i), strap[8*i+:8]);
    end
    host_u.wr_reg(IDX_COPRO_TEST, 8'h01);
    settle(1);
    chk("copro_on", {cps, cpro}, 2'h3);
    host_u.wr_reg(IDX_COPRO_TEST, 8'h00);
    settle(1);
    chk("copro_off", {cps, cpro}, 2'h0);
    cpr <= 1'b1;
    settle(1);
    chk("copro_pass", {cps, cpro}, 2'h1);
    cpr <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      host_u.wr_reg(IDX_TEST_CTL, 8'(b << TC_FLUSH));
      @(posedge clock_i);
      mdone <= 1'b1;
      @(posedge clock_i);
      mdone <= 1'b0;
      #1;
      chk("flush", cfl, b);
      settle(1);
      chk("flush_end", cfl, 1'b0);
    end
    host_u.wr_reg(IDX_TEST_CTL, 8'h20);
    settle(3);
    chk("vsync_rise", vso, 1'b1);
    settle(4);
    chk("vsync_once", vso, 1'b1);
    vs <= 1'b1;
    settle(1);
    chk("vsync_pass", vso, 1'b0);
    vs <= 1'b0;
    host_u.wr_reg(IDX_TEST_CTL, 8'h00);
    settle(3);
    chk("vsync_back", vso, 1'b0);
    for (int s = 0; s < 8; s++) begin
      host_u.wr_reg(IDX_TEST_CTL, 8'h40 | 8'(s));
      settle(2);
      chk("debug_pins", pxo, {s < 7 ? dbg[8*s+:8] : 8'h00, pix[15:0]});
    end
    @(posedge clock_i);
    txt <= 1'b1;
    host_u.wr_reg(IDX_TEST_CTL, {5'h10, MODE_SCAN_ATR});
    settle(2);
    chk("scan_text", {fo, ao}, sdi);
    chk("pixel_pass", pxo, pix);
    txt <= 1'b0;
    settle(2);
    chk("scan_gfx", so, sdi[15:8]);
    host_u.wr_reg(IDX_TEST_CTL, {5'h00, MODE_SCAN_ATR});
    settle(2);
    chk("no_global", so, gpx);
    host_u.wr_reg(IDX_TEST_CTL, 8'h80);
    // Counter starts at 0 the edge after the write; each slice shows one cycle later
    for (int k = 0; k < 9; k++) begin
      settle(1);
      chk("crt_slice", {sdoe, sdo}, {1'b1, sl(k % 8)});
    end
    host_u.wr_reg(IDX_TEST_CTL, 8'h00);
    settle(2);
    chk("crt_off", {sdoe, sdo}, 17'h0);
    end_of_test();
  end
endmodule
